//--- core/cfg_seq_pkg.sv
/*
 Shared constants, state codes and the state record of the configuration
 start-up sequencer. Assumes a 250 MHz core clock and 32-bit AXI4-Lite.
*/
package cfg_seq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int INIT_MIN_US = 50;
  localparam int INIT_MAX_US = 250;
  localparam int POR_MS = 16;
  localparam int INIT_MIN_CYC = (INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int INIT_MAX_CYC = (INIT_MAX_US * 1000) / CLK_NS;
  localparam int POR_CYC = (POR_MS * 1000000) / CLK_NS;
  localparam logic [22:0] MODE_WAIT = 23'h000002;
  localparam logic [22:0] SYNC_SLACK = 23'h000003;
  localparam logic [3:0] SLOW_HALF = 4'h8;
  localparam logic [3:0] FAST_HALF = 4'h1;
  // ----------------------------------------------------------------
  // Bitstream layout
  // ----------------------------------------------------------------
  localparam logic [7:0] NUM_FRAMES = 8'h08;
  localparam logic [4:0] FRAME_DATA = 5'h10;
  localparam logic [4:0] FRAME_LAST = 5'h14;
  localparam logic [4:0] LEN_LAST = 5'h17;
  localparam logic [3:0] PREAMBLE = 4'h2;
  localparam logic [3:0] ERR_FIELD = 4'h6;
  localparam int OPT_FAST = 0;
  localparam int OPT_DONE = 1;
  localparam int OPT_IO = 3;
  localparam int OPT_GSR = 5;
  localparam int OPT_SYNC = 7;
  localparam int OPT_UCLK = 8;
  localparam logic [4:0] OPT_LAST = 5'h09;
  localparam logic [1:0] PH_PRE = 2'h0;
  localparam logic [1:0] PH_LEN = 2'h1;
  localparam logic [1:0] PH_FRM = 2'h2;
  localparam logic [1:0] PH_FULL = 2'h3;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_LENGTH = 5'h08;
  localparam logic [4:0] REG_COUNT = 5'h0C;
  localparam int CTRL_RECONF = 0;
  localparam int CTRL_SLOW = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [7:0] {
    ST_CLEAR = 8'h01,
    ST_CLEAR_LAST = 8'h02,
    ST_INIT_WAIT = 8'h04,
    ST_INIT_DELAY = 8'h08,
    ST_MODE = 8'h10,
    ST_CONFIG = 8'h20,
    ST_FAULT = 8'h40,
    ST_STARTUP = 8'h80
  } state_e;

  typedef struct packed {
    state_e st;
    logic [22:0] tmr;
    logic por_done;
    logic [7:0] fa;
    logic [1:0] prog_sy, init_sy, ckin_sy, din_sy, done_sy, uclk_sy;
    logic [2:0] mode_s1, mode_s2, mode;
    logic ckin_pv, uclk_pv, held, master;
    logic [1:0] ph;
    logic [3:0] pre;
    logic [23:0] len, ccnt;
    logic [4:0] bpos;
    logic [7:0] fcnt;
    logic [8:0] opt;
    logic fast, ckout, dout, err;
    logic [3:0] div;
    logic [4:0] q;
    logic done_rel, io_act, gsr_hold, init_oe, hi_cfg, lo_cfg;
    logic [1:0] ctrl, bresp, rresp;
    logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, aw_have, w_have;
    logic [4:0] awa;
    logic [31:0] wd, rdata;
    logic wstb;
  } seq_s;
endpackage

//--- core/cfg_startup_seq.sv
/*
 Configuration-control sequencer: memory clear, open-drain init handshake,
 mode capture, bitstream header and frame parsing, daisy-chain output,
 configuration clock generation and the programmable start-up register.
 Assumes all pins are asynchronous to i_mclk and an AXI4-Lite master.
*/
// Functional notes
// - Stay clearing frames while power-on timer runs or reconfig held.
// - After each pass test both; if idle, clear once more, then wait.
// - Init and done drive low, low-config low, high-config high from reset.
// - Release the init pin only after the final clearing pass.
// - Master waits 50 to 250 us before taking init as high.
// - Two clocks after init high, capture mode pins and start loading.
// - Find preamble 0010, then take 24 bits as length count.
// - After header, hold daisy-chain output high.
// - Master runs slow clock until first-frame rate bit picks eightfold.
// - Frame error field mismatch stops loading and pulls init low.
// - With own frames loaded, forward input data downstream again.
// - Reconfig request pulls init low; on release clear and restart.
// - External init hold stalls after clear; release captures mode.
// - After an external hold a master waits a further 250 us.
// - Done, I/O and reset release each pick any of stages two to five.
// - Default: done first, I/O next clock, reset release after that.
// - Start-up needs full memory and clock count equal to length.
// - Next clock edge sets first stage of five-stage start-up register.
// - Synchronous modes gate the fourth stage with the done pin level.
// - External low on done stalls start-up until it reads high.
// - Later stages step on config clock or on the user clock.
// - With user clock, second stage bridges the two clock phases.
// - Clock counter starts at the very first config clock.
`timescale 1ns/10ps
module cfg_startup_seq #(
  parameter int POR_CYCLES = cfg_seq_pkg::POR_CYC,
  parameter int INIT_MIN_CYCLES = cfg_seq_pkg::INIT_MIN_CYC,
  parameter int INIT_MAX_CYCLES = cfg_seq_pkg::INIT_MAX_CYC
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [4:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [4:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_program_n,
  input wire logic i_init_n,
  output logic o_init_n,
  output logic o_init_n_oe,
  input wire logic i_done,
  output logic o_done,
  output logic o_done_oe,
  input wire logic [2:0] i_mode,
  input wire logic i_config_clock,
  output logic o_config_clock,
  input wire logic i_din,
  output logic o_dout,
  input wire logic i_user_startup_clock,
  output logic o_high_during_config_out,
  output logic o_low_during_config_out,
  output logic o_io_active,
  output logic o_global_reset
);
  localparam logic [22:0] POR_END = 23'(POR_CYCLES - 1);
  localparam logic [22:0] MIN_END = 23'(INIT_MIN_CYCLES - 1);
  localparam logic [22:0] MAX_END = 23'(INIT_MAX_CYCLES - 1);

  cfg_seq_pkg::seq_s s_q, s_d;

  // Picks stage (sel + base) + 2 of the start-up register.
  function automatic logic stage_pick(input logic [4:0] q,
                                      input logic [1:0] sel,
                                      input logic [1:0] base);
    logic [1:0] idx;
    idx = sel + base;
    return q[3'(idx) + 3'h1];
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One process computes the whole next state; pins enter via two flops.
  always_comb begin
    logic reconf, cedge, sedge, din, run;
    logic [3:0] half;
    s_d = s_q;
    reconf = 1'b0;
    cedge = 1'b0;
    sedge = 1'b0;
    din = s_q.din_sy[1];
    run = 1'b0;
    half = cfg_seq_pkg::SLOW_HALF;
    s_d.prog_sy = {s_q.prog_sy[0], i_program_n};
    s_d.init_sy = {s_q.init_sy[0], i_init_n};
    s_d.ckin_sy = {s_q.ckin_sy[0], i_config_clock};
    s_d.din_sy = {s_q.din_sy[0], i_din};
    s_d.done_sy = {s_q.done_sy[0], i_done};
    s_d.uclk_sy = {s_q.uclk_sy[0], i_user_startup_clock};
    s_d.mode_s1 = i_mode;
    s_d.mode_s2 = s_q.mode_s1;
    s_d.ckin_pv = s_q.ckin_sy[1];
    s_d.uclk_pv = s_q.uclk_sy[1];
    reconf = !s_q.prog_sy[1] || s_q.ctrl[cfg_seq_pkg::CTRL_RECONF];

    // The master divides the core clock; fast only once the bit is seen.
    run = s_q.master && (s_q.st == cfg_seq_pkg::ST_CONFIG ||
                         s_q.st == cfg_seq_pkg::ST_STARTUP);
    if (s_q.fast && !s_q.ctrl[cfg_seq_pkg::CTRL_SLOW]) begin
      half = cfg_seq_pkg::FAST_HALF;
    end
    if (run) begin
      if (s_q.div == 4'h0) begin
        s_d.div = half - 4'h1;
        s_d.ckout = !s_q.ckout;
        cedge = !s_q.ckout;
      end else begin
        s_d.div = s_q.div - 4'h1;
      end
    end else if (!s_q.master) begin
      cedge = s_q.ckin_sy[1] && !s_q.ckin_pv;
    end

    if (reconf) begin
      // Request forces init low and restarts the clearing.
      s_d.st = cfg_seq_pkg::ST_CLEAR;
      s_d.init_oe = 1'b1;
      s_d.fa = 8'h00;
      s_d.err = 1'b0;
      s_d.q = 5'h00;
      s_d.done_rel = 1'b0;
      s_d.io_act = 1'b0;
      s_d.gsr_hold = 1'b1;
      s_d.ckout = 1'b0;
      s_d.dout = 1'b1;
    end else begin
      unique case (s_q.st)
        cfg_seq_pkg::ST_CLEAR: begin
          s_d.init_oe = 1'b1;
          if (!s_q.por_done) begin
            s_d.tmr = s_q.tmr + 23'h1;
            s_d.por_done = s_q.tmr == POR_END;
          end
          s_d.fa = s_q.fa + 8'h1;
          if (s_q.fa == cfg_seq_pkg::NUM_FRAMES - 8'h1) begin
            s_d.fa = 8'h00;
            if (s_q.por_done) begin
              s_d.st = cfg_seq_pkg::ST_CLEAR_LAST;
            end
          end
        end
        cfg_seq_pkg::ST_CLEAR_LAST: begin
          s_d.fa = s_q.fa + 8'h1;
          if (s_q.fa == cfg_seq_pkg::NUM_FRAMES - 8'h1) begin
            s_d.fa = 8'h00;
            s_d.st = cfg_seq_pkg::ST_INIT_WAIT;
            s_d.init_oe = 1'b0;
            s_d.tmr = 23'h0;
          end
        end
        cfg_seq_pkg::ST_INIT_WAIT: begin
          // Low beyond the sync slack means someone outside holds it.
          s_d.tmr = s_q.tmr + 23'h1;
          if (s_q.init_sy[1]) begin
            s_d.held = s_q.tmr > cfg_seq_pkg::SYNC_SLACK;
            s_d.tmr = 23'h0;
            s_d.st = s_q.mode_s2[0] ? cfg_seq_pkg::ST_MODE
                                    : cfg_seq_pkg::ST_INIT_DELAY;
          end
        end
        cfg_seq_pkg::ST_INIT_DELAY: begin
          s_d.tmr = s_q.tmr + 23'h1;
          if (s_q.tmr == (s_q.held ? MAX_END : MIN_END)) begin
            s_d.st = cfg_seq_pkg::ST_MODE;
            s_d.tmr = 23'h0;
          end
        end
        cfg_seq_pkg::ST_MODE: begin
          s_d.tmr = s_q.tmr + 23'h1;
          if (s_q.tmr == cfg_seq_pkg::MODE_WAIT - 23'h1) begin
            s_d.mode = s_q.mode_s2;
            s_d.master = !s_q.mode_s2[0];
            s_d.st = cfg_seq_pkg::ST_CONFIG;
            s_d.ph = cfg_seq_pkg::PH_PRE;
            s_d.pre = 4'hF;
            s_d.ccnt = 24'h0;
            s_d.bpos = 5'h00;
            s_d.fcnt = 8'h00;
            s_d.fast = 1'b0;
            s_d.div = 4'h0;
            s_d.ckout = 1'b0;
          end
        end
        cfg_seq_pkg::ST_CONFIG: begin
          if (cedge) begin
            s_d.ccnt = s_q.ccnt + 24'h1;
            unique case (s_q.ph)
              cfg_seq_pkg::PH_PRE: begin
                s_d.dout = din;
                s_d.pre = {s_q.pre[2:0], din};
                if ({s_q.pre[2:0], din} == cfg_seq_pkg::PREAMBLE) begin
                  s_d.ph = cfg_seq_pkg::PH_LEN;
                  s_d.bpos = 5'h00;
                end
              end
              cfg_seq_pkg::PH_LEN: begin
                s_d.dout = din;
                s_d.len = {s_q.len[22:0], din};
                s_d.bpos = s_q.bpos + 5'h1;
                if (s_q.bpos == cfg_seq_pkg::LEN_LAST) begin
                  s_d.ph = cfg_seq_pkg::PH_FRM;
                  s_d.bpos = 5'h00;
                end
              end
              cfg_seq_pkg::PH_FRM: begin
                s_d.dout = 1'b1;
                if (s_q.bpos == 5'h00) begin
                  s_d.bpos = {4'h0, !din};
                end else begin
                  s_d.bpos = s_q.bpos + 5'h1;
                end
                // Options only come from the first frame.
                if (s_q.fcnt == 8'h00 && s_q.bpos != 5'h00 &&
                    s_q.bpos <= cfg_seq_pkg::OPT_LAST) begin
                  s_d.opt[4'(s_q.bpos - 5'h1)] = din;
                  if (s_q.bpos == 5'h01) begin
                    s_d.fast = din;
                  end
                end
                if (s_q.bpos > cfg_seq_pkg::FRAME_DATA &&
                    din != cfg_seq_pkg::ERR_FIELD[
                      2'(cfg_seq_pkg::FRAME_LAST - s_q.bpos)]) begin
                  s_d.st = cfg_seq_pkg::ST_FAULT;
                  s_d.init_oe = 1'b1;
                  s_d.err = 1'b1;
                end
                if (s_q.bpos == cfg_seq_pkg::FRAME_LAST) begin
                  s_d.bpos = 5'h00;
                  s_d.fcnt = s_q.fcnt + 8'h1;
                  if (s_q.fcnt == cfg_seq_pkg::NUM_FRAMES - 8'h1) begin
                    s_d.ph = cfg_seq_pkg::PH_FULL;
                  end
                end
              end
              default: begin
                s_d.dout = din;
              end
            endcase
          end
          // Memory full and exact count; a short count waits for more clocks, a long one for the wrap.
          if (s_q.ph == cfg_seq_pkg::PH_FULL && s_q.ccnt == s_q.len) begin
            s_d.st = cfg_seq_pkg::ST_STARTUP;
          end
        end
        cfg_seq_pkg::ST_FAULT: begin
          s_d.init_oe = 1'b1;
        end
        cfg_seq_pkg::ST_STARTUP: begin
          if (cedge) begin
            s_d.dout = din;
            s_d.q[0] = 1'b1;
          end
          // The user clock path reaches stage two only after a sync.
          sedge = s_q.opt[cfg_seq_pkg::OPT_UCLK]
                  ? (s_q.uclk_sy[1] && !s_q.uclk_pv) : cedge;
          if (sedge) begin
            s_d.q[1] = s_q.q[0];
            s_d.q[2] = s_q.q[1];
            s_d.q[3] = s_q.q[2] && (!s_q.opt[cfg_seq_pkg::OPT_SYNC] ||
                                    s_q.done_sy[1]);
            s_d.q[4] = s_q.q[3];
          end
          // Option zero gives done, then I/O, then reset release.
          s_d.done_rel = stage_pick(s_q.q,
            s_q.opt[cfg_seq_pkg::OPT_DONE +: 2], 2'h0);
          s_d.io_act = stage_pick(s_q.q,
            s_q.opt[cfg_seq_pkg::OPT_IO +: 2], 2'h1);
          s_d.gsr_hold = !stage_pick(s_q.q,
            s_q.opt[cfg_seq_pkg::OPT_GSR +: 2], 2'h2);
        end
        default: begin
          s_d.st = cfg_seq_pkg::ST_CLEAR;
        end
      endcase
    end
    s_d.hi_cfg = !s_d.io_act;
    s_d.lo_cfg = s_d.io_act;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    if (s_q.aw_rdy && i_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.awa = i_awaddr;
    end
    if (s_q.w_rdy && i_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.wd = i_wdata;
      s_d.wstb = i_wstrb[0];
    end
    if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
    end
    // The write lands once both halves are held; one write at a time.
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = cfg_seq_pkg::RESP_OKAY;
      if (s_q.awa == cfg_seq_pkg::REG_CTRL) begin
        if (s_q.wstb) begin
          s_d.ctrl = s_q.wd[1:0];
        end
      end else if (s_q.awa != cfg_seq_pkg::REG_STATUS &&
                   s_q.awa != cfg_seq_pkg::REG_LENGTH &&
                   s_q.awa != cfg_seq_pkg::REG_COUNT) begin
        s_d.bresp = cfg_seq_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.ar_rdy && i_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = cfg_seq_pkg::RESP_OKAY;
      unique case (i_araddr)
        cfg_seq_pkg::REG_CTRL: s_d.rdata = {30'h0, s_q.ctrl};
        cfg_seq_pkg::REG_STATUS: begin
          s_d.rdata = {15'h0, s_q.err, s_q.mode, s_q.q, s_q.st};
        end
        cfg_seq_pkg::REG_LENGTH: s_d.rdata = {8'h00, s_q.len};
        cfg_seq_pkg::REG_COUNT: s_d.rdata = {8'h00, s_q.ccnt};
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = cfg_seq_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_d.aw_rdy = !s_d.aw_have && !s_d.bvalid;
    s_d.w_rdy = !s_d.w_have && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset loads constants only; the clock enable freezes everything.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.st <= cfg_seq_pkg::ST_CLEAR;
      s_q.prog_sy <= 2'h3;
      s_q.pre <= 4'hF;
      s_q.dout <= 1'b1;
      s_q.init_oe <= 1'b1;
      s_q.hi_cfg <= 1'b1;
      s_q.gsr_hold <= 1'b1;
      s_q.ctrl <= cfg_seq_pkg::CTRL_RST;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // Open-drain pins only ever pull low, so the driven level is zero.
  assign o_init_n = 1'b0;
  assign o_init_n_oe = s_q.init_oe;
  assign o_done = 1'b0;
  assign o_done_oe = !s_q.done_rel;
  assign o_config_clock = s_q.ckout;
  assign o_dout = s_q.dout;
  assign o_high_during_config_out = s_q.hi_cfg;
  assign o_low_during_config_out = s_q.lo_cfg;
  assign o_io_active = s_q.io_act;
  assign o_global_reset = s_q.gsr_hold;
  assign o_awready = s_q.aw_rdy;
  assign o_wready = s_q.w_rdy;
  assign o_bvalid = s_q.bvalid;
  assign o_bresp = s_q.bresp;
  assign o_arready = s_q.ar_rdy;
  assign o_rvalid = s_q.rvalid;
  assign o_rdata = s_q.rdata;
  assign o_rresp = s_q.rresp;
endmodule

//--- dv/cfg_seq_props.sv
/*
 Concurrent checks of the start-up sequencer, bound to its top module.
 Assumes a single core clock domain and an active-low async reset.
*/
`timescale 1ns/10ps
module cfg_seq_props (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_program_n,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic o_init_n_oe,
  input wire logic o_done_oe,
  input wire logic o_high_during_config_out,
  input wire logic o_low_during_config_out,
  input wire logic o_io_active,
  input wire logic o_global_reset
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Everything runs on the core clock and is idle while reset is low.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_prog_low;
    !i_program_n [*4];
  endsequence
  property p_status;
    o_high_during_config_out == !o_io_active &&
      o_low_during_config_out == o_io_active;
  endproperty
  property p_por;
    $rose(i_resetn) |-> o_init_n_oe [*8];
  endproperty
  property p_prog;
    s_prog_low |=> o_init_n_oe;
  endproperty
  // A released request still costs a whole clearing pass of frames.
  property p_clear;
    $rose(i_program_n) |-> o_init_n_oe [*8];
  endproperty
  property p_rel;
    $fell(o_init_n_oe) |-> o_done_oe && $past(i_program_n);
  endproperty
  property p_done;
    $fell(o_done_oe) |-> !o_init_n_oe;
  endproperty
  property p_io;
    $rose(o_io_active) |-> !o_init_n_oe;
  endproperty
  property p_gsr;
    $fell(o_global_reset) |-> !o_init_n_oe && !o_done_oe;
  endproperty
  property p_rd;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_status: assert property (p_status)
    else $error("status pins out of step");
  a_por: assert property (p_por)
    else $error("init released during power-on clear");
  a_prog: assert property (p_prog)
    else $error("init not pulled while reconfig held");
  a_clear: assert property (p_clear)
    else $error("init released without a clearing pass");
  a_rel: assert property (p_rel)
    else $error("init released at the wrong moment");
  a_done: assert property (p_done)
    else $error("done released while init pulled");
  a_io: assert property (p_io)
    else $error("io active while init pulled");
  a_gsr: assert property (p_gsr)
    else $error("reset released while init or done pulled");
  a_rd: assert property (p_rd)
    else $error("read answer late");
endmodule
bind cfg_startup_seq cfg_seq_props cfg_seq_props_i (.*);

//--- dv/cfg_source_model.sv
/*
 Serial bitstream source standing in for a PROM in slave mode.
 Assumes the bench loads the bit vector and pulses the start input.
*/
`timescale 1ns/10ps
module cfg_source_model (
  input wire logic i_go,
  input wire logic [8:0] i_n,
  input wire logic [299:0] i_bits,
  output logic o_link_clk,
  output logic o_din,
  output logic o_busy
);
  // ----------------------------------------------------------------
  // Stream
  // ----------------------------------------------------------------
  initial begin
    o_link_clk = 0;
    o_din = 0;
    o_busy = 0;
  end
  // The clock stands still between streams; data is set 40 ns ahead of
  // each rising edge and held 120 ns after it.
  always @(posedge i_go) begin
    o_busy = 1;
    #13;
    for (int j = 0; j < i_n; j++) begin
      o_din = i_bits[j];
      #40 o_link_clk = 1;
      #80 o_link_clk = 0;
      #40;
    end
    // The line is released, so show the opposite of the last bit.
    o_din = ~o_din;
    o_busy = 0;
  end
endmodule

//--- dv/fpga_config_startup_sequencer_test.sv
/*
 Self-checking bench of the start-up sequencer in slave serial mode.
 Assumes the source model drives the link and pull-ups on init and done.
*/
`timescale 1ns/10ps
module fpga_config_startup_sequencer_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_mclk = 0, i_resetn = 0, i_ce = 1, i_program_n = 1;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_user_startup_clock = 0;
  logic [4:0] i_awaddr = 5'h00, i_araddr = 5'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] i_wstrb = 4'hF;
  logic [2:0] i_mode;
  logic [1:0] o_bresp, o_rresp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_init_n;
  logic o_init_n_oe, o_done, o_done_oe, o_config_clock, o_dout;
  logic o_high_during_config_out, o_low_during_config_out;
  logic o_io_active, o_global_reset, i_config_clock, i_din, busy;
  logic go = 0, dchk = 0, ext_init = 1, ext_done = 0, pd, pi, pg;
  logic [299:0] bits, edo;
  logic [8:0] nb = 9'h000;
  int seed = 7803, error_cnt = 0, n_checks = 0;
  int k = 0, td, ti, tg, len, nbits;
  wire i_init_n, i_done;

  always #2 i_mclk = ~i_mclk;
  always #7 i_user_startup_clock = ~i_user_startup_clock;
  // Open-drain pins are pulled up unless some party pulls them down.
  assign i_init_n = !(o_init_n_oe | ext_init);
  assign i_done = !(o_done_oe | ext_done);

  cfg_startup_seq #(.POR_CYCLES(20), .INIT_MIN_CYCLES(10),
    .INIT_MAX_CYCLES(30)) cfg_startup_seq_i (.*);
  cfg_source_model cfg_source_model_i (.i_go(go), .i_n(nb),
    .i_bits(bits), .o_link_clk(i_config_clock), .o_din(i_din),
    .o_busy(busy));

  // ----------------------------------------------------------------
  // Model and monitors
  // ----------------------------------------------------------------
  // Link edges are counted so start-up events get a clock index.
  always @(posedge i_config_clock) k++;
  always @(negedge i_config_clock)
    if (dchk) chk("dout", edo[k-1], o_dout);
  always @(posedge i_mclk) begin
    if (pd && !o_done_oe) td <= k;
    if (!pi && o_io_active) ti <= k;
    if (pg && !o_global_reset) tg <= k;
    pd <= o_done_oe;
    pi <= o_io_active;
    pg <= o_global_reset;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task final_report;
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task stop;
    $display("BAD wait expected answer seen timeout");
    error_cnt++;
    final_report();
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    for (int t = 0; t < lim && s !== v; t++) @(posedge i_mclk);
    if (s !== v) stop();
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    for (t = 0; t < 99 && !(o_bvalid && i_bready); t++) begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end
    if (t > 98) stop();
    i_bready <= 0;
    chk("bresp", er, o_bresp);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    int t;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    for (t = 0; t < 99 && !(o_rvalid && i_rready); t++) begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 0;
    end
    if (t > 98) stop();
    i_rready <= 0;
    chk("rdata", e, o_rdata & m);
    chk("rresp", er, o_rresp);
  endtask
  // Builds leading ones, header, eight frames and four closing clocks.
  // First-frame option bits come from op, indexed by data bit position.
  task mk(input logic bad, input logic [10:0] op);
    int f, d;
    len = 30 + 8 * (cfg_seq_pkg::FRAME_DATA + 5);
    bits = '1;
    for (d = 0; d < 28; d++)
      bits[2+d] = d < 4 ? cfg_seq_pkg::PREAMBLE[3-d] : len[27-d];
    for (f = 0; f < 8; f++)
      for (d = 0; d < 21; d++)
        bits[30+f*21+d] = d == 0 ? 1'b0 : d > 16 ?
          cfg_seq_pkg::ERR_FIELD[20-d] ^ (bad && f == 3) :
          f == 0 && d < 11 ? op[d] : 1'($random(seed));
    for (d = 0; d < 4; d++) bits[len+d] = 1'b0;
    nbits = len + 4;
    for (d = 0; d < nbits; d++) edo[d] = d >= 30 && d < len ? 1'b1 : bits[d];
  endtask
  task send(input int n);
    nb <= 9'(n);
    k = 0;
    go <= 1;
    @(posedge i_mclk);
    go <= 0;
    wt(busy, 1'b0, 30000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_mode <= {2'($random(seed)), 1'b1};
    repeat (10) @(posedge i_mclk);
    chk("hi_cfg", 1, o_high_during_config_out);
    chk("lo_cfg", 0, o_low_during_config_out);
    chk("init", 1, o_init_n_oe);
    chk("done", 1, o_done_oe);
    i_resetn <= 1;
    repeat (100) @(posedge i_mclk);
    wr(cfg_seq_pkg::REG_STATUS, 32'hFF, 2'h0);
    rd(cfg_seq_pkg::REG_STATUS, 32'hFF, 32'h04, 2'h0);
    rd(cfg_seq_pkg::REG_CTRL, '1, 32'h0, 2'h0);
    wr(cfg_seq_pkg::REG_CTRL, 32'h2, 2'h0);
    rd(cfg_seq_pkg::REG_CTRL, '1, 32'h2, 2'h0);
    wr(5'h10, 32'h1, cfg_seq_pkg::RESP_SLVERR);
    rd(5'h14, '1, 32'h0, cfg_seq_pkg::RESP_SLVERR);
    wr(cfg_seq_pkg::REG_CTRL, 32'h0, 2'h0);
    ext_init <= 0;
    repeat (200) @(posedge i_mclk);
    rd(cfg_seq_pkg::REG_STATUS, 32'hE0FF, {i_mode, 13'h20}, 2'h0);
    mk(0, 11'h000);
    dchk = 1;
    send(nbits);
    dchk = 0;
    chk("done_at", len + 2, td);
    chk("io_at", td + 1, ti);
    chk("gsr_at", ti + 1, tg);
    chk("hi_cfg", 0, o_high_during_config_out);
    chk("lo_cfg", 1, o_low_during_config_out);
    chk("ckout", 0, o_config_clock);
    rd(cfg_seq_pkg::REG_LENGTH, '1, len, 2'h0);
    rd(cfg_seq_pkg::REG_STATUS, 32'hFF, 32'h80, 2'h0);
    wr(cfg_seq_pkg::REG_CTRL, 32'h1, 2'h0);
    repeat (5) @(posedge i_mclk);
    chk("init", 1, o_init_n_oe);
    wr(cfg_seq_pkg::REG_CTRL, 32'h0, 2'h0);
    wt(o_init_n_oe, 1'b0, 500);
    repeat (200) @(posedge i_mclk);
    mk(1, 11'h000);
    send(nbits);
    chk("init", 1, o_init_n_oe);
    chk("pulls", 0, {o_init_n, o_done});
    rd(cfg_seq_pkg::REG_STATUS, 32'h100FF, 32'h10040, 2'h0);
    i_program_n <= 0;
    repeat (20) @(posedge i_mclk);
    chk("init", 1, o_init_n_oe);
    // The request must have left the fault and cleared the error flag.
    rd(cfg_seq_pkg::REG_STATUS, 32'h100FF, 32'h01, 2'h0);
    i_program_n <= 1;
    wt(o_init_n_oe, 1'b0, 500);
    ext_done <= 1;
    repeat (200) @(posedge i_mclk);
    // Sync to done; I/O moves up to the second stage, reset to the last.
    mk(0, 11'h170);
    send(nbits);
    chk("gsr", 1, o_global_reset);
    chk("io_at", len + 2, ti);
    ext_done <= 0;
    send(4);
    chk("gsr", 0, o_global_reset);
    chk("gsr_at", 2, tg);
    final_report();
  end
endmodule
